// File: flash_ctrl_pkg.sv
// Constants and types for the flash mode and self-program controller.
// Assumes one 100 MHz clock and all pin inputs synchronous to it.
// Contract
// - Pin a low: normal; a high, b low: program
// - Programming uses only chosen serial channel pins
// - Unused pins keep their reset state
// - Boot swap exchanges blocks 0-15 with 16-31
// - No flash fetch during self-programming
// - NMI vectors to internal RAM start
// - Maskable interrupt vectors to RAM start plus 4
// - Flash rewrite allowed only while pin a high
// - Pin a pulses pick channel: 0, 8, 11
package flash_ctrl_pkg;

    localparam logic [7:0] pulses_clocked = 8'h08;
    localparam logic [7:0] pulses_handshake = 8'h0b;
    localparam logic [4:0] swap_half_bit = 5'h10;
    localparam logic [31:0] ram_vec_nmi_offset = 32'h0000_0000;
    localparam logic [31:0] ram_vec_maskable_offset = 32'h0000_0004;
    localparam int select_window_us = 1000;
    localparam int clk_mhz = 100;
    localparam int select_window_cycles = select_window_us * clk_mhz;

    typedef enum logic [3:0] {
        mode_reset = 4'b0001,
        mode_normal = 4'b0010,
        mode_program = 4'b0100,
        mode_prohibited = 4'b1000
    } op_mode_t;

    typedef enum logic [4:0] {
        chan_none = 5'b00001,
        chan_selecting = 5'b00010,
        chan_async = 5'b00100,
        chan_clocked = 5'b01000,
        chan_clocked_hs = 5'b10000
    } chan_t;

    typedef struct packed {
        logic async_en;
        logic clocked_en;
        logic handshake_en;
        logic reserved_sel;
    } pin_route_t;

endpackage

// File: pulse_counter.sv
// Counts rising edges on the first mode pin during a fixed selection window.
// Assumes the pin is synchronous to mclk and the window is started once.
`timescale 1ns/1ps
module pulse_counter #(
    parameter int window_cycles = flash_ctrl_pkg::select_window_cycles
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Control
    input wire logic start,
    input wire logic pin_level,
    // Result
    output logic done,
    output logic [7:0] count
);
    logic [31:0] timer_q;
    logic running_q;
    logic pin_prev_q;
    logic [7:0] count_q;
    logic done_q;
    wire rise = pin_level & ~pin_prev_q;
    wire expire = running_q && (timer_q == 32'(window_cycles - 1));

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            timer_q <= 32'h0;
            running_q <= 1'b0;
            pin_prev_q <= 1'b0;
            count_q <= 8'h0;
            done_q <= 1'b0;
        end
        else
        begin
            pin_prev_q <= pin_level;
            if (start && !running_q && !done_q)
                running_q <= 1'b1;
            if (running_q)
                timer_q <= timer_q + 32'h1;
            // Saturate so a runaway pulse train cannot wrap into a legal count
            if (running_q && rise && count_q != 8'hff)
                count_q <= count_q + 8'h1;
            if (expire)
            begin
                running_q <= 1'b0;
                done_q <= 1'b1;
            end
        end
    end

    assign done = done_q;
    assign count = count_q;
endmodule // pulse_counter

// File: flash_mode_and_self_program_ctrl.sv
// Top of the flash mode and self-program controller.
// Assumes rst is driven only by the programmer while in programming mode.
`timescale 1ns/1ps
module flash_mode_and_self_program_ctrl #(
    parameter int select_window = flash_ctrl_pkg::select_window_cycles
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Mode pins
    input wire logic flash_mode_pin_a,
    input wire logic flash_mode_pin_b,
    input wire logic debug_unit_reset_n,
    // Self-programming control from the core
    input wire logic self_prog_active,
    input wire logic block_half_swap_call,
    input wire logic write_req,
    input wire logic nmi_req,
    input wire logic maskable_req,
    input wire logic [31:0] ram_base,
    input wire logic [31:0] flash_nmi_vec,
    input wire logic [31:0] flash_maskable_vec,
    input wire logic [4:0] logical_block,
    // Serial pins
    input wire logic async_receive_pin,
    input wire logic clocked_data_in_pin,
    input wire logic clocked_serial_clock_pin,
    input wire logic link_tx_data,
    input wire logic link_hs_level,
    output logic async_transmit_pin,
    output logic async_transmit_oe,
    output logic clocked_data_out_pin,
    output logic clocked_data_out_oe,
    output logic programmer_handshake_pin,
    output logic programmer_handshake_oe,
    output logic link_rx_data,
    output logic link_sclk,
    // Status
    output flash_ctrl_pkg::op_mode_t op_mode,
    output flash_ctrl_pkg::chan_t channel,
    output flash_ctrl_pkg::pin_route_t route,
    output logic pins_at_reset_state,
    output logic flash_fetch_block,
    output logic write_allowed,
    output logic swapped,
    output logic [4:0] physical_block,
    output logic vec_valid,
    output logic [31:0] vec_addr
);
    flash_ctrl_pkg::op_mode_t mode_q;
    flash_ctrl_pkg::op_mode_t mode_d;
    flash_ctrl_pkg::chan_t chan_q;
    flash_ctrl_pkg::chan_t chan_d;
    logic swapped_q;
    logic vec_valid_q;
    logic [31:0] vec_q;
    logic [31:0] vec_d;
    logic cnt_done;
    logic [7:0] cnt_val;

    // Mode decode at reset release: pin a low wins regardless of pin b
    wire mode_normal_sel = !flash_mode_pin_a;
    wire mode_program_sel = flash_mode_pin_a && !flash_mode_pin_b;

    always_comb
    begin
        mode_d = mode_q;
        if (mode_q == flash_ctrl_pkg::mode_reset)
        begin
            if (mode_normal_sel)
                mode_d = flash_ctrl_pkg::mode_normal;
            else if (mode_program_sel)
                mode_d = flash_ctrl_pkg::mode_program;
            else
                mode_d = flash_ctrl_pkg::mode_prohibited;
        end
    end

    wire in_prog = (mode_q == flash_ctrl_pkg::mode_program);

    pulse_counter #(
        .window_cycles(select_window)
    ) u_count (
        .mclk(mclk),
        .rst(rst),
        .start(in_prog),
        .pin_level(flash_mode_pin_a),
        .done(cnt_done),
        .count(cnt_val)
    );

    always_comb
    begin
        chan_d = chan_q;
        case (chan_q)
            // A finished window never reopens selection, so a reserved count stays parked
            flash_ctrl_pkg::chan_none:
                if (in_prog && !cnt_done)
                    chan_d = flash_ctrl_pkg::chan_selecting;
            flash_ctrl_pkg::chan_selecting:
                if (cnt_done)
                begin
                    if (cnt_val == 8'h00)
                        chan_d = flash_ctrl_pkg::chan_async;
                    else if (cnt_val == flash_ctrl_pkg::pulses_clocked)
                        chan_d = flash_ctrl_pkg::chan_clocked;
                    else if (cnt_val == flash_ctrl_pkg::pulses_handshake)
                        chan_d = flash_ctrl_pkg::chan_clocked_hs;
                    else
                        chan_d = flash_ctrl_pkg::chan_none;
                end
            default:
                chan_d = chan_q;
        endcase
    end

    // Reserved count parks the link; a fresh reset is needed to retry
    wire reserved_pick = in_prog && cnt_done && (chan_q == flash_ctrl_pkg::chan_none);

    // Serial routing: only the chosen channel's pins come alive
    wire use_async = (chan_q == flash_ctrl_pkg::chan_async);
    wire use_clk = (chan_q == flash_ctrl_pkg::chan_clocked) ||
        (chan_q == flash_ctrl_pkg::chan_clocked_hs);
    wire use_hs = (chan_q == flash_ctrl_pkg::chan_clocked_hs);

    // Self-programming gates; debug reset high would corrupt a write, so refuse it
    wire sp = self_prog_active && (mode_q == flash_ctrl_pkg::mode_normal);
    wire wr_ok = sp && flash_mode_pin_a && !debug_unit_reset_n;

    // Five block bits span exactly both halves, so a swap remaps every block

    always_comb
    begin
        vec_d = 32'h0;
        if (nmi_req)
            vec_d = sp ? ram_base + flash_ctrl_pkg::ram_vec_nmi_offset : flash_nmi_vec;
        else if (maskable_req)
            vec_d = sp ? ram_base + flash_ctrl_pkg::ram_vec_maskable_offset
                : flash_maskable_vec;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            mode_q <= flash_ctrl_pkg::mode_reset;
            chan_q <= flash_ctrl_pkg::chan_none;
            swapped_q <= 1'b0;
            vec_valid_q <= 1'b0;
            vec_q <= 32'h0;
        end
        else
        begin
            mode_q <= mode_d;
            chan_q <= chan_d;
            if (sp && block_half_swap_call && wr_ok)
                swapped_q <= ~swapped_q;
            vec_valid_q <= nmi_req || maskable_req;
            vec_q <= vec_d;
        end
    end

    assign op_mode = mode_q;
    assign channel = chan_q;
    assign route = '{async_en: use_async, clocked_en: use_clk,
        handshake_en: use_hs, reserved_sel: reserved_pick};
    // Every pin outside the chosen channel stays undriven as after reset
    assign pins_at_reset_state = in_prog;
    assign async_transmit_pin = use_async ? link_tx_data : 1'b0;
    assign async_transmit_oe = use_async;
    assign clocked_data_out_pin = use_clk ? link_tx_data : 1'b0;
    assign clocked_data_out_oe = use_clk;
    assign programmer_handshake_pin = use_hs ? link_hs_level : 1'b0;
    assign programmer_handshake_oe = use_hs;
    assign link_rx_data = use_async ? async_receive_pin :
        (use_clk ? clocked_data_in_pin : 1'b1);
    assign link_sclk = use_clk ? clocked_serial_clock_pin : 1'b0;
    assign flash_fetch_block = sp;
    assign write_allowed = wr_ok && write_req;
    assign swapped = swapped_q;
    assign physical_block = swapped_q ?
        (logical_block ^ flash_ctrl_pkg::swap_half_bit) : logical_block;
    assign vec_valid = vec_valid_q;
    assign vec_addr = vec_q;

    chk_mode_latch_hold: assert property (@(posedge mclk) disable iff (rst)
        (mode_q != flash_ctrl_pkg::mode_reset) |=> $stable(mode_q))
        else $error("mode changed after latch");
    chk_mode_normal_sel: assert property (@(posedge mclk) disable iff (rst)
        (mode_q == flash_ctrl_pkg::mode_reset && !flash_mode_pin_a)
        |=> mode_q == flash_ctrl_pkg::mode_normal)
        else $error("pin a low did not give normal");
    chk_mode_prog_sel: assert property (@(posedge mclk) disable iff (rst)
        (mode_q == flash_ctrl_pkg::mode_reset && flash_mode_pin_a && !flash_mode_pin_b)
        |=> mode_q == flash_ctrl_pkg::mode_program)
        else $error("programming mode not entered");
    chk_channel_pins: assert property (@(posedge mclk) disable iff (rst)
        !(async_transmit_oe && clocked_data_out_oe))
        else $error("two channels driven");
    chk_unused_quiet: assert property (@(posedge mclk) disable iff (rst)
        (chan_q == flash_ctrl_pkg::chan_async) |-> !programmer_handshake_oe
        && !clocked_data_out_oe)
        else $error("unused pin driven");
    chk_chan_eight: assert property (@(posedge mclk) disable iff (rst)
        (chan_q == flash_ctrl_pkg::chan_selecting && cnt_done && cnt_val == 8'h08)
        |=> chan_q == flash_ctrl_pkg::chan_clocked)
        else $error("eight pulses not clocked channel");
    chk_write_gate: assert property (@(posedge mclk) disable iff (rst)
        write_allowed |-> flash_mode_pin_a && self_prog_active)
        else $error("write without pin a high");
    chk_nmi_vector: assert property (@(posedge mclk) disable iff (rst)
        (nmi_req && sp) |=> vec_valid && vec_addr == $past(ram_base))
        else $error("nmi not to ram start");
    chk_mask_vector: assert property (@(posedge mclk) disable iff (rst)
        (maskable_req && !nmi_req && sp) |=> vec_addr == $past(ram_base) + 32'h4)
        else $error("maskable not to ram plus 4");
    chk_swap_map: assert property (@(posedge mclk) disable iff (rst)
        (swapped_q && logical_block < 5'h10) |-> physical_block == logical_block + 5'h10)
        else $error("swap mapping wrong");
    chk_fetch_block: assert property (@(posedge mclk) disable iff (rst)
        sp |-> flash_fetch_block)
        else $error("flash fetch during self-program");
    chk_reserved_park: assert property (@(posedge mclk) disable iff (rst)
        (in_prog && cnt_done && chan_q == flash_ctrl_pkg::chan_none)
        |=> chan_q == flash_ctrl_pkg::chan_none)
        else $error("reserved count left parked state");
    chk_swap_refused: assert property (@(posedge mclk) disable iff (rst)
        (block_half_swap_call && !wr_ok) |=> $stable(swapped_q))
        else $error("swap taken while writes refused");
endmodule // flash_mode_and_self_program_ctrl

// File: programmer.sv
// Behavioural model of the external programmer and the board wiring around the device.
// Assumes the bench calls its tasks from one process, just after a rising clock edge.
`timescale 1ns/1ps
module programmer (
    // Clock
    input wire logic mclk,
    // Reset and mode pins
    output logic rst,
    output logic flash_mode_pin_a,
    output logic flash_mode_pin_b,
    output logic debug_unit_reset_n,
    // Serial inputs of the device
    output logic async_receive_pin,
    output logic clocked_data_in_pin,
    output logic clocked_serial_clock_pin
);
    logic drive_q = 1'b0;
    logic bit_q = 1'b0;
    logic idle_q = 1'b0;

    initial
    begin
        rst = 1'b1;
        flash_mode_pin_a = 1'b0;
        flash_mode_pin_b = 1'b0;
        debug_unit_reset_n = 1'b0;
        clocked_serial_clock_pin = 1'b0;
    end

    // Released lines toggle every cycle so a stale bit never passes for live data
    always @(posedge mclk)
        idle_q <= ~idle_q;
    assign async_receive_pin = drive_q ? bit_q : idle_q;
    assign clocked_data_in_pin = drive_q ? bit_q : idle_q;

    // Only the programmer pulls reset; mode pins stay put across the release
    task automatic do_reset(input logic a, input logic b);
        rst = 1'b1;
        flash_mode_pin_a = a;
        flash_mode_pin_b = b;
        debug_unit_reset_n = 1'b0;
        repeat (3) @(posedge mclk);
        #1 rst = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
    endtask

    // One low and one high cycle a pulse, so eleven fit well inside the window
    task automatic pulses(input int n);
        repeat (n)
        begin
            @(posedge mclk);
            #1 flash_mode_pin_a = 1'b0;
            @(posedge mclk);
            #1 flash_mode_pin_a = 1'b1;
        end
    endtask

    task automatic set_pins(input logic a, input logic b, input logic d);
        flash_mode_pin_a = a;
        flash_mode_pin_b = b;
        debug_unit_reset_n = d;
    endtask

    task automatic send_bit(input logic v);
        bit_q = v;
        drive_q = 1'b1;
        clocked_serial_clock_pin = 1'b1;
        #1;
    endtask

    task automatic release_lines;
        drive_q = 1'b0;
        clocked_serial_clock_pin = 1'b0;
    endtask
endmodule // programmer

// File: tb.sv
// Self-checking bench for the flash mode and self-program controller.
// Assumes the programmer model owns reset, mode pins and the serial inputs.
`timescale 1ns/1ps
module tb;
    localparam int win = 50;
    logic mclk = 1'b0;
    logic rst, pin_a, pin_b, debug_unit_reset_n_n, rxd, sdi, sck, txd, txd_oe, sdo, sdo_oe, hs, hs_oe, rx, sclk;
    logic sp = 1'b0, swap = 1'b0, wreq = 1'b0, nmi = 1'b0, mreq = 1'b0, ltx = 1'b0, lhs = 1'b0;
    logic [31:0] ram = 32'h0, fnmi = 32'h0, fmask = 32'h0, vaddr;
    logic [4:0] lblk = 5'h00, pblk;
    logic [3:0] r;
    logic pins_rst, fetch_blk, wr_ok, swapped, vvalid, v;
    flash_ctrl_pkg::op_mode_t op_mode;
    flash_ctrl_pkg::chan_t channel;
    flash_ctrl_pkg::pin_route_t route;
    int failures = 0, n_compared = 0, seed = 32'he8cd;
    int counts[5] = '{0, 8, 11, 5, 12};

    always #5 mclk = ~mclk;

    programmer u_programmer (.mclk(mclk), .rst(rst), .flash_mode_pin_a(pin_a),
        .flash_mode_pin_b(pin_b), .debug_unit_reset_n(debug_unit_reset_n_n), .async_receive_pin(rxd),
        .clocked_data_in_pin(sdi), .clocked_serial_clock_pin(sck));
    flash_mode_and_self_program_ctrl #(.select_window(win)) u_flash_mode_and_self_program_ctrl (
        .mclk(mclk), .rst(rst), .flash_mode_pin_a(pin_a), .flash_mode_pin_b(pin_b),
        .debug_unit_reset_n(debug_unit_reset_n_n), .self_prog_active(sp), .block_half_swap_call(swap),
        .write_req(wreq), .nmi_req(nmi), .maskable_req(mreq), .ram_base(ram),
        .flash_nmi_vec(fnmi), .flash_maskable_vec(fmask), .logical_block(lblk),
        .async_receive_pin(rxd), .clocked_data_in_pin(sdi), .clocked_serial_clock_pin(sck),
        .link_tx_data(ltx), .link_hs_level(lhs), .async_transmit_pin(txd),
        .async_transmit_oe(txd_oe), .clocked_data_out_pin(sdo), .clocked_data_out_oe(sdo_oe),
        .programmer_handshake_pin(hs), .programmer_handshake_oe(hs_oe), .link_rx_data(rx),
        .link_sclk(sclk), .op_mode(op_mode), .channel(channel), .route(route),
        .pins_at_reset_state(pins_rst), .flash_fetch_block(fetch_blk), .write_allowed(wr_ok),
        .swapped(swapped), .physical_block(pblk), .vec_valid(vvalid), .vec_addr(vaddr));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        if (failures == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    function automatic logic [3:0] exp_mode(input logic a, input logic b);
        return !a ? 4'h2 : (b ? 4'h8 : 4'h4);
    endfunction

    // Route bits are async, clocked, handshake, reserved
    function automatic logic [3:0] exp_route(input int n);
        return n == 0 ? 4'b1000 : n == 8 ? 4'b0100 : n == 11 ? 4'b0110 : 4'b0001;
    endfunction

    initial
    begin
        #1;
        for (int i = 0; i < 4; i++)
        begin
            u_programmer.do_reset(i[1], i[0]);
            check(op_mode, exp_mode(i[1], i[0]));
            check(pins_rst, i[1] & ~i[0]);
            u_programmer.set_pins(~i[1], ~i[0], 1'b0);
            tick(3);
            check(op_mode, exp_mode(i[1], i[0]));
        end
        foreach (counts[k])
        begin
            u_programmer.do_reset(1'b1, 1'b0);
            check(pins_rst, 1'b1);
            u_programmer.pulses(counts[k]);
            ltx = 1'($random(seed));
            lhs = 1'($random(seed));
            tick(win + 4);
            r = exp_route(counts[k]);
            check(channel, r[0] ? 5'h01 : r[3] ? 5'h04 : r[1] ? 5'h10 : 5'h08);
            check(route, r);
            check({txd_oe, sdo_oe, hs_oe}, r[3:1]);
            check(txd, r[3] & ltx);
            check(sdo, r[2] & ltx);
            check(hs, r[1] & lhs);
            v = 1'($random(seed));
            u_programmer.send_bit(v);
            check(rx, r[0] ? 1'b1 : v);
            check(sclk, r[2]);
            u_programmer.release_lines();
        end
        u_programmer.do_reset(1'b0, 1'($random(seed)));
        sp = 1'b1;
        wreq = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            u_programmer.set_pins(i[0], 1'b0, i[1]);
            tick(1);
            check(fetch_blk, 1'b1);
            check(wr_ok, i[0] & ~i[1]);
        end
        for (int i = 0; i < 8; i++)
        begin
            ram = $random(seed);
            fnmi = $random(seed);
            fmask = $random(seed);
            sp = i[0];
            nmi = i[1];
            mreq = i[2] | ~i[1];
            tick(1);
            check(vvalid, 1'b1);
            check(fetch_blk, i[0]);
            check(vaddr, i[0] ? ram + (i[1] ? 32'h0 : 32'h4) : (i[1] ? fnmi : fmask));
        end
        nmi = 1'b0;
        mreq = 1'b0;
        sp = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            u_programmer.set_pins(i < 3, 1'b0, 1'b0);
            lblk = $random(seed);
            swap = 1'b1;
            tick(1);
            swap = 1'b0;
            tick(1);
            check(pblk, lblk ^ (i == 1 ? 5'h00 : 5'h10));
            check(swapped, i != 1);
            check(vvalid, 1'b0);
        end
        summarize();
    end

    // Whole run needs well under ten thousand cycles
    initial
    begin
        #100000;
        failures++;
        summarize();
    end
endmodule // tb
